// File: design/qst_map.svh
// bit positions, register selectors and sizes of the data-quality status tree
`ifndef QST_MAP_SVH
`define QST_MAP_SVH
`define QST_W          16
`define QST_NREG       5
`define QST_SEL_W      3
`define QST_MAX_TRACES 16
`define QST_LOW_TRACES 14
`define QST_TOP_HEALTH 9
`define QST_TOP_LIMIT  10
`define QST_LOW_CHAIN  0
`define QST_LOW_FIRST  1
`define QST_HIGH_T15   1
`define QST_HIGH_T16   2
`define QST_HEALTH_HW  2
`define QST_HW_PLL     1
`define QST_HW_LEVEL   2
`define QST_HW_OVLD    3
`define QST_MAX_SLOTS  256
`define QST_MSB        (`QST_W - 1)
`define QST_HIGH_UNUSED 0
`define QST_SEL_TOP    3'h0
`define QST_SEL_LOW    3'h1
`define QST_SEL_HIGH   3'h2
`define QST_SEL_HEALTH 3'h3
`define QST_SEL_FAULT  3'h4
`endif

// File: design/qst_pkg.sv
// types shared by the data-quality status tree
package qst_pkg;
  typedef logic [15:0] word_t;
  typedef logic [2:0]  reg_sel_t;
  typedef struct packed
  {
    logic     valid;
    reg_sel_t sel;
    logic     event_view;
  } query_t;
  typedef struct packed
  {
    logic     valid;
    reg_sel_t sel;
    word_t    data;
  } enable_wr_t;
  typedef struct packed
  {
    logic  valid;
    word_t data;
  } reply_t;
endpackage

// File: design/questionable_status_tree.sv
// data-quality and hardware-fault status tree with condition and event views and write-only enable masks
// Overview of operation
// - top bit 9 is set while any latched health-summary bit is set with its enable bit.
// - top bit 10 is set while any latched low trace-check bit is set with its enable bit.
// - low trace-check bit 0 summarises the high trace-check register through its enable bits.
// - low trace-check bits 1 to 14 flag a limit failure on traces 1 to 14.
// - high trace-check bits 1 and 2 flag traces 15 and 16, bit 0 stays clear.
// - trace slots of lower-numbered channels come before those of higher channels.
// - within a channel the oldest trace takes the lowest slot and the newest the highest.
// - only the first 16 trace slots are watched, later ones never raise a flag.
// - health-summary bit 2 summarises the hardware-fault register through its enable bits.
// - hardware-fault bit 1 flags loss of lock of the 10 MHz reference loop.
// - hardware-fault bit 2 flags unsettled or unstable output level control.
// - hardware-fault bit 3 flags a tripped receiver overload protection.
// - every register can be read either as its condition view or as its event view.
// - the masked summary of the top word drives status byte bit 3.
`timescale 1ns/1ps
`include "qst_map.svh"
module questionable_status_tree
  import qst_pkg::*;
#(
  parameter int NUM_SLOTS = 24
)
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic [NUM_SLOTS-1:0] trace_fail_slot,
  input  wire logic                 ref_pll_unlock,
  input  wire logic                 level_unsettled,
  input  wire logic                 rx_overload_trip,
  input  wire query_t               query,
  input  wire enable_wr_t           enable_wr,
  output reply_t                    reply,
  output logic                      status_byte_qst
);

  if (NUM_SLOTS < `QST_MAX_TRACES || NUM_SLOTS > `QST_MAX_SLOTS)
  begin : g_slot_chk
    $error("NUM_SLOTS must lie between 16 and 256");
  end

  function automatic logic masked_sum(input word_t bits, input word_t mask);
    masked_sum = |(bits & mask);
  endfunction

  word_t  cond_q [`QST_NREG];
  word_t  ev_q   [`QST_NREG];
  word_t  en_q   [`QST_NREG];
  word_t  cond_d [`QST_NREG];
  reply_t reply_q;
  logic   stb_q;

  wire logic [`QST_MAX_TRACES-1:0] watched = trace_fail_slot[`QST_MAX_TRACES-1:0];

  wire logic health_sum = masked_sum(ev_q[`QST_SEL_HEALTH], en_q[`QST_SEL_HEALTH]);
  wire logic low_sum    = masked_sum(ev_q[`QST_SEL_LOW], en_q[`QST_SEL_LOW]);
  wire logic high_sum   = masked_sum(ev_q[`QST_SEL_HIGH], en_q[`QST_SEL_HIGH]);
  wire logic fault_sum  = masked_sum(ev_q[`QST_SEL_FAULT], en_q[`QST_SEL_FAULT]);
  wire logic top_sum    = masked_sum(ev_q[`QST_SEL_TOP], en_q[`QST_SEL_TOP]);

  always_comb
  begin
    for (int r = 0; r < `QST_NREG; r++)
      cond_d[r] = '0;
    cond_d[`QST_SEL_TOP][`QST_TOP_HEALTH] = health_sum;
    cond_d[`QST_SEL_TOP][`QST_TOP_LIMIT]  = low_sum;
    cond_d[`QST_SEL_LOW][`QST_LOW_CHAIN]  = high_sum;
    cond_d[`QST_SEL_LOW][`QST_LOW_FIRST +: `QST_LOW_TRACES] = watched[`QST_LOW_TRACES-1:0];
    cond_d[`QST_SEL_HIGH][`QST_HIGH_T15] = watched[`QST_LOW_TRACES];
    cond_d[`QST_SEL_HIGH][`QST_HIGH_T16] = watched[`QST_LOW_TRACES+1];
    cond_d[`QST_SEL_HEALTH][`QST_HEALTH_HW] = fault_sum;
    cond_d[`QST_SEL_FAULT][`QST_HW_PLL]   = ref_pll_unlock;
    cond_d[`QST_SEL_FAULT][`QST_HW_LEVEL] = level_unsettled;
    cond_d[`QST_SEL_FAULT][`QST_HW_OVLD]  = rx_overload_trip;
  end

  wire logic   sel_ok   = query.sel <= `QST_SEL_FAULT;
  wire logic   ev_read  = query.valid & query.event_view & sel_ok;
  wire word_t  view     = query.event_view ? ev_q[query.sel] : cond_q[query.sel];
  wire reply_t reply_d  = '{valid: query.valid, data: (query.valid & sel_ok) ? view : '0};

  // an event-view read clears the event word, but a rise in the same cycle survives
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int r = 0; r < `QST_NREG; r++)
      begin
        cond_q[r] <= '0;
        ev_q[r]   <= '0;
        en_q[r]   <= '0;
      end
    end
    else
    begin
      for (int r = 0; r < `QST_NREG; r++)
      begin
        cond_q[r] <= cond_d[r];
        ev_q[r]   <= ((ev_read && query.sel == reg_sel_t'(r)) ? '0 : ev_q[r]) | (cond_d[r] & ~cond_q[r]);
        if (enable_wr.valid && enable_wr.sel == reg_sel_t'(r))
          en_q[r] <= enable_wr.data;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      reply_q <= '0;
      stb_q   <= 1'b0;
    end
    else
    begin
      reply_q <= reply_d;
      stb_q   <= top_sum;
    end
  end

  assign reply           = reply_q;
  assign status_byte_qst = stb_q;

  sequence health_event_s;
    masked_sum(ev_q[`QST_SEL_HEALTH], en_q[`QST_SEL_HEALTH]);
  endsequence

  sequence low_event_s;
    masked_sum(ev_q[`QST_SEL_LOW], en_q[`QST_SEL_LOW]);
  endsequence

  top_health_a: assert property (@(posedge ref_clk) disable iff (rst)
    health_event_s |=> cond_q[`QST_SEL_TOP][`QST_TOP_HEALTH])
    else $error("top health summary not raised");

  top_health_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
    !masked_sum(ev_q[`QST_SEL_HEALTH], en_q[`QST_SEL_HEALTH]) |=> !cond_q[`QST_SEL_TOP][`QST_TOP_HEALTH])
    else $error("top health summary set without cause");

  top_limit_a: assert property (@(posedge ref_clk) disable iff (rst)
    low_event_s |=> cond_q[`QST_SEL_TOP][`QST_TOP_LIMIT])
    else $error("top limit summary not raised");

  low_chain_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> cond_q[`QST_SEL_LOW][`QST_LOW_CHAIN] == $past(high_sum))
    else $error("low register chain bit wrong");

  low_trace_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> cond_q[`QST_SEL_LOW][`QST_LOW_TRACES:`QST_LOW_FIRST] == $past(trace_fail_slot[`QST_LOW_TRACES-1:0]))
    else $error("low trace bits do not follow traces 1 to 14");

  high_trace_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> cond_q[`QST_SEL_HIGH][`QST_HIGH_T16:`QST_HIGH_T15]
             == $past(trace_fail_slot[`QST_LOW_TRACES+1:`QST_LOW_TRACES])
             && !cond_q[`QST_SEL_HIGH][`QST_HIGH_UNUSED])
    else $error("high trace bits wrong");

  excess_trace_a: assert property (@(posedge ref_clk) disable iff (rst)
    cond_q[`QST_SEL_HIGH][`QST_MSB:`QST_HIGH_T16+1] == '0 && !cond_q[`QST_SEL_LOW][`QST_MSB])
    else $error("unwatched trace raised a flag");

  health_chain_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> cond_q[`QST_SEL_HEALTH][`QST_HEALTH_HW] == $past(fault_sum))
    else $error("health summary does not follow fault register");

  fault_bits_a: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> cond_q[`QST_SEL_FAULT][`QST_HW_OVLD:`QST_HW_PLL] == $past({rx_overload_trip, level_unsettled, ref_pll_unlock}))
    else $error("hardware fault bits wrong");

  query_view_a: assert property (@(posedge ref_clk) disable iff (rst)
    query.valid && !query.event_view && query.sel == `QST_SEL_FAULT
    |=> reply.valid && reply.data == $past(cond_q[`QST_SEL_FAULT]))
    else $error("condition view reply wrong");

  stb_bit_a: assert property (@(posedge ref_clk) disable iff (rst)
    status_byte_qst == $past(top_sum))
    else $error("status byte bit does not follow top summary");

  event_latch_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(cond_q[`QST_SEL_FAULT][`QST_HW_PLL]) |-> ev_q[`QST_SEL_FAULT][`QST_HW_PLL])
    else $error("event did not latch on rising condition");

  event_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    ev_q[`QST_SEL_TOP][`QST_TOP_LIMIT] && !(query.valid && query.event_view && query.sel == `QST_SEL_TOP)
    |=> ev_q[`QST_SEL_TOP][`QST_TOP_LIMIT])
    else $error("event lost without a read");

  sequence fault_ev_read_s;
    query.valid && query.event_view && query.sel == `QST_SEL_FAULT;
  endsequence

  sequence top_ev_read_s;
    query.valid && query.event_view && query.sel == `QST_SEL_TOP;
  endsequence

  top_limit_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
    !low_sum |=> !cond_q[`QST_SEL_TOP][`QST_TOP_LIMIT])
    else $error("top limit summary set without cause");

  top_health_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
    en_q[`QST_SEL_HEALTH] == '0 |=> !cond_q[`QST_SEL_TOP][`QST_TOP_HEALTH])
    else $error("masked health summary reached top word");

  top_limit_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
    en_q[`QST_SEL_LOW] == '0 |=> !cond_q[`QST_SEL_TOP][`QST_TOP_LIMIT])
    else $error("masked trace summary reached top word");

  chain_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
    en_q[`QST_SEL_HIGH] == '0 |=> !cond_q[`QST_SEL_LOW][`QST_LOW_CHAIN])
    else $error("masked high trace register reached low register");

  health_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
    en_q[`QST_SEL_FAULT] == '0 |=> !cond_q[`QST_SEL_HEALTH][`QST_HEALTH_HW])
    else $error("masked fault register reached health summary");

  stb_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
    en_q[`QST_SEL_TOP] == '0 |=> !status_byte_qst)
    else $error("masked top word reached status byte bit");

  top_cond_view_a: assert property (@(posedge ref_clk) disable iff (rst)
    query.valid && !query.event_view && query.sel == `QST_SEL_TOP
    |=> reply.valid && reply.data == $past(cond_q[`QST_SEL_TOP]))
    else $error("top condition view reply wrong");

  low_cond_view_a: assert property (@(posedge ref_clk) disable iff (rst)
    query.valid && !query.event_view && query.sel == `QST_SEL_LOW
    |=> reply.valid && reply.data == $past(cond_q[`QST_SEL_LOW]))
    else $error("low trace condition view reply wrong");

  high_cond_view_a: assert property (@(posedge ref_clk) disable iff (rst)
    query.valid && !query.event_view && query.sel == `QST_SEL_HIGH
    |=> reply.valid && reply.data == $past(cond_q[`QST_SEL_HIGH]))
    else $error("high trace condition view reply wrong");

  health_cond_view_a: assert property (@(posedge ref_clk) disable iff (rst)
    query.valid && !query.event_view && query.sel == `QST_SEL_HEALTH
    |=> reply.valid && reply.data == $past(cond_q[`QST_SEL_HEALTH]))
    else $error("health condition view reply wrong");

  fault_ev_view_a: assert property (@(posedge ref_clk) disable iff (rst)
    fault_ev_read_s |=> reply.valid && reply.data == $past(ev_q[`QST_SEL_FAULT]))
    else $error("fault event view reply wrong");

  top_ev_view_a: assert property (@(posedge ref_clk) disable iff (rst)
    top_ev_read_s |=> reply.valid && reply.data == $past(ev_q[`QST_SEL_TOP]))
    else $error("top event view reply wrong");

  unmapped_reply_a: assert property (@(posedge ref_clk) disable iff (rst)
    query.valid && query.sel > `QST_SEL_FAULT |=> reply.valid && reply.data == '0)
    else $error("unmapped selector returned data");

  reply_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
    !query.valid |=> !reply.valid)
    else $error("reply without a query");

  health_ev_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(cond_q[`QST_SEL_HEALTH][`QST_HEALTH_HW]) |-> ev_q[`QST_SEL_HEALTH][`QST_HEALTH_HW])
    else $error("health event did not latch");

  top_ev_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(cond_q[`QST_SEL_TOP][`QST_TOP_LIMIT]) |-> ev_q[`QST_SEL_TOP][`QST_TOP_LIMIT])
    else $error("top limit event did not latch");

  low_ev_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(cond_q[`QST_SEL_LOW][`QST_LOW_FIRST]) |-> ev_q[`QST_SEL_LOW][`QST_LOW_FIRST])
    else $error("low trace event did not latch");

  high_ev_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(cond_q[`QST_SEL_HIGH][`QST_HIGH_T15]) |-> ev_q[`QST_SEL_HIGH][`QST_HIGH_T15])
    else $error("high trace event did not latch");

  fault_ev_rise_a: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(cond_q[`QST_SEL_FAULT][`QST_HW_OVLD]) |-> ev_q[`QST_SEL_FAULT][`QST_HW_OVLD])
    else $error("overload event did not latch");

  fault_ev_src_a: assert property (@(posedge ref_clk) disable iff (rst)
    ev_q[`QST_SEL_FAULT][`QST_HW_PLL] && !$rose(cond_q[`QST_SEL_FAULT][`QST_HW_PLL])
    |-> $past(ev_q[`QST_SEL_FAULT][`QST_HW_PLL]))
    else $error("fault event set without a rising condition");

  top_ev_src_a: assert property (@(posedge ref_clk) disable iff (rst)
    ev_q[`QST_SEL_TOP][`QST_TOP_HEALTH] && !$rose(cond_q[`QST_SEL_TOP][`QST_TOP_HEALTH])
    |-> $past(ev_q[`QST_SEL_TOP][`QST_TOP_HEALTH]))
    else $error("top event set without a rising condition");

  low_ev_src_a: assert property (@(posedge ref_clk) disable iff (rst)
    ev_q[`QST_SEL_LOW][`QST_LOW_FIRST] && !$rose(cond_q[`QST_SEL_LOW][`QST_LOW_FIRST])
    |-> $past(ev_q[`QST_SEL_LOW][`QST_LOW_FIRST]))
    else $error("low trace event set without a rising condition");

  fault_ev_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
    fault_ev_read_s |=> ev_q[`QST_SEL_FAULT] == (cond_q[`QST_SEL_FAULT] & ~$past(cond_q[`QST_SEL_FAULT])))
    else $error("fault event word not cleared by its read");

  top_ev_clr_a: assert property (@(posedge ref_clk) disable iff (rst)
    top_ev_read_s |=> ev_q[`QST_SEL_TOP] == (cond_q[`QST_SEL_TOP] & ~$past(cond_q[`QST_SEL_TOP])))
    else $error("top event word not cleared by its read");

  health_ev_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    ev_q[`QST_SEL_HEALTH][`QST_HEALTH_HW] && !(query.valid && query.event_view && query.sel == `QST_SEL_HEALTH)
    |=> ev_q[`QST_SEL_HEALTH][`QST_HEALTH_HW])
    else $error("health event lost without a read");

  fault_ev_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    ev_q[`QST_SEL_FAULT][`QST_HW_LEVEL] && !(query.valid && query.event_view && query.sel == `QST_SEL_FAULT)
    |=> ev_q[`QST_SEL_FAULT][`QST_HW_LEVEL])
    else $error("fault event lost without a read");

  enable_wr_a: assert property (@(posedge ref_clk) disable iff (rst)
    enable_wr.valid && enable_wr.sel == `QST_SEL_FAULT |=> en_q[`QST_SEL_FAULT] == $past(enable_wr.data))
    else $error("fault enable mask not written");

  enable_keep_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(enable_wr.valid && enable_wr.sel == `QST_SEL_TOP) |=> $stable(en_q[`QST_SEL_TOP]))
    else $error("top enable mask changed without a write");

endmodule

// File: bench/tb_questionable_status_tree.sv
// self-checking bench for the data-quality status tree
`timescale 1ns/1ps
module tb_questionable_status_tree
  import qst_pkg::*;
;
  logic        ref_clk;
  logic        rst;
  logic [23:0] trace_fail_slot;
  logic        ref_pll_unlock;
  logic        level_unsettled;
  logic        rx_overload_trip;
  query_t      query;
  enable_wr_t  enable_wr;
  reply_t      reply;
  logic        status_byte_qst;
  int          miscompares;
  int          n_compared;
  int          cycles;

  questionable_status_tree #(.NUM_SLOTS(24)) dut_u
  (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .trace_fail_slot  (trace_fail_slot),
    .ref_pll_unlock   (ref_pll_unlock),
    .level_unsettled  (level_unsettled),
    .rx_overload_trip (rx_overload_trip),
    .query            (query),
    .enable_wr        (enable_wr),
    .reply            (reply),
    .status_byte_qst  (status_byte_qst)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // hang guard, the whole sequence needs just under 100 cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input word_t exp, input word_t got);
    n_compared++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  // lets status changes ripple through every summary level
  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input reg_sel_t sel, input word_t data);
    enable_wr = '{1'b1, sel, data};
    @(posedge ref_clk);
    #1;
    enable_wr.valid = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  // reply is registered at the edge that takes the query
  task automatic rd(input reg_sel_t sel, input logic ev, input word_t exp, input string name);
    query = '{1'b1, sel, ev};
    @(posedge ref_clk);
    #1;
    query.valid = 1'b0;
    chk({name, " valid"}, 16'h0001, {15'h0000, reply.valid});
    chk(name, exp, reply.data);
    @(posedge ref_clk);
    #1;
  endtask

  initial
  begin
    rst = 1'b1;
    trace_fail_slot = 24'h000000;
    ref_pll_unlock = 1'b0;
    level_unsettled = 1'b0;
    rx_overload_trip = 1'b0;
    query = '0;
    enable_wr = '0;
    repeat (4) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    rd(3'h4, 1'b0, 16'h0000, "fault cond at reset");
    chk("status byte at reset", 16'h0000, {15'h0000, status_byte_qst});
    for (int s = 0; s < 5; s++) wr(reg_sel_t'(s), 16'hFFFF);
    trace_fail_slot = 24'hFF0000;
    settle();
    rd(3'h2, 1'b0, 16'h0000, "high cond late slots");
    rd(3'h1, 1'b0, 16'h0000, "low cond late slots");
    ref_pll_unlock = 1'b1;
    settle();
    rd(3'h4, 1'b0, 16'h0002, "fault cond lock loss");
    rd(3'h3, 1'b0, 16'h0004, "health cond");
    rd(3'h0, 1'b0, 16'h0200, "top cond health");
    chk("status byte bit", 16'h0001, {15'h0000, status_byte_qst});
    level_unsettled = 1'b1;
    rx_overload_trip = 1'b1;
    settle();
    rd(3'h4, 1'b0, 16'h000E, "fault cond all");
    rd(3'h4, 1'b1, 16'h000E, "fault event");
    rd(3'h4, 1'b1, 16'h0000, "fault event after read");
    trace_fail_slot = 24'hFFFFFF;
    settle();
    rd(3'h2, 1'b0, 16'h0006, "high cond");
    rd(3'h1, 1'b0, 16'h7FFF, "low cond");
    rd(3'h0, 1'b0, 16'h0600, "top cond both");
    wr(3'h2, 16'h0000);
    settle();
    rd(3'h1, 1'b0, 16'h7FFE, "low cond high masked");
    trace_fail_slot = 24'h002001;
    settle();
    rd(3'h1, 1'b0, 16'h4002, "low cond first and last");
    rd(3'h0, 1'b1, 16'h0600, "top event");
    chk("status byte after top read", 16'h0000, {15'h0000, status_byte_qst});
    rd(3'h5, 1'b0, 16'h0000, "unmapped selector");
    test_done();
  end
endmodule
